// *** verilog/status_concentrator.v ***
// What this block does
// - Eight channels each hold status, interrupt mask and interrupt request registers, plus one board register, all readable and writable.
// - Status bits are L1 busy, L1 error, L2 busy, L2 error, link sync error, init ack, two spares, cable disconnected; higher bits reserved.
// - The host addresses registers by status enable, slot, channel and offsets 0x0, 0x2, 0x4, 0x6 in span 0x400 to 0x7fe.
// - The status register reads the live status inputs and may be written for diagnostics.
// - A set mask bit enables interrupts for its status bit, a clear one disables them.
// - A rising status bit with its mask set sets the request bit and raises an interrupt.
// - Request bits stay latched until written with zero; ones leave them; reset clears them all.
// - A cleared request returns only on a fresh inactive-to-active transition.
// - Board bit zero enables module interrupts and is reached at offset 0x6 under any channel.
// - An active interrupt drives the VME request, the hub's front-panel output and an indicator.
// - The block answers only when status access is enabled and its own slot is addressed.
// - Framework data passes straight through to the fanout board without registering.
// - A subset of channel status signals is forwarded back to the trigger frameworks.
`timescale 1ns/1ps
`include "status_concentrator_regs.vh"

module status_concentrator
#(
    parameter CHANNELS = 8,
    parameter FRAMEWORK_WIDTH = 48,
    parameter [3:0] SLOT_ID = 4'h0
)
(
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Backplane register access
    input wire status_enable,
    input wire [3:0] slot_addr,
    input wire [2:0] channel_addr,
    input wire [2:0] reg_offset,
    input wire bus_write,
    input wire bus_read,
    input wire [15:0] bus_wdata,
    output reg [15:0] bus_rdata,
    output reg bus_rdata_oe_n,
    output reg bus_ack,
    // Status from the serial receivers
    input wire [9*CHANNELS-1:0] status_in,
    // Status forwarded to the frameworks
    output reg [4*CHANNELS-1:0] framework_status,
    // Framework data pass-through
    input wire [FRAMEWORK_WIDTH-1:0] framework_in,
    output wire [FRAMEWORK_WIDTH-1:0] fanout_out,
    // Interrupt
    output reg irq_out,
    output reg irq_led
);

// ----------------------------------------
// Local constants
// ----------------------------------------
localparam [15:0] RDATA_IDLE = 16'h0000;
localparam [15:0] BOARD_RESET = `RESET_BOARD;
localparam [4*CHANNELS-1:0] FORWARD_IDLE = {4*CHANNELS{1'b0}};

// ----------------------------------------
// Internal signals
// ----------------------------------------
wire selected;
wire take_write;
wire take_read;
wire board_write;
wire [CHANNELS-1:0] chan_onehot;
wire [CHANNELS-1:0] chan_write;
wire [CHANNELS-1:0] chan_pending;
wire any_pending;
wire [9*CHANNELS-1:0] status_all;
wire [9*CHANNELS-1:0] mask_all;
wire [9*CHANNELS-1:0] request_all;
reg board_enable;
reg [8:0] read_status;
reg [8:0] read_mask;
reg [8:0] read_request;
reg [15:0] next_rdata;
reg next_ack;
reg next_oe_n;
reg next_irq;
reg [4*CHANNELS-1:0] next_framework_status;
genvar g;
integer i;

// ----------------------------------------
// Decode and data helpers
// ----------------------------------------
// Channel registers hold nine bits; the upper bits of the word read zero
function [15:0] pad9;
    input [8:0] value;
    begin
        pad9 = {7'h00, value};
    end
endfunction

function is_status_reg;
    input [2:0] off;
    begin
        is_status_reg = (off == `OFF_CHANNEL_STATUS);
    end
endfunction

function is_mask_reg;
    input [2:0] off;
    begin
        is_mask_reg = (off == `OFF_CHANNEL_INTERRUPT_MASK);
    end
endfunction

function is_request_reg;
    input [2:0] off;
    begin
        is_request_reg = (off == `OFF_CHANNEL_INTERRUPT_REQUEST);
    end
endfunction

function is_board_reg;
    input [2:0] off;
    begin
        is_board_reg = (off == `OFF_BOARD_INTERRUPT_ENABLE);
    end
endfunction

// One bit per channel, set for the addressed channel
function [CHANNELS-1:0] channel_onehot;
    input [2:0] ch;
    integer k;
    begin
        channel_onehot = {CHANNELS{1'b0}};
        for (k = 0; k < CHANNELS; k = k + 1)
        begin
            if (ch == k[2:0])
                channel_onehot[k] = 1'b1;
        end
    end
endfunction

// Picks one channel's nine bits out of a flattened register bus
function [8:0] pick9;
    input [9*CHANNELS-1:0] flat;
    input [CHANNELS-1:0] onehot;
    integer k;
    begin
        pick9 = 9'h000;
        for (k = 0; k < CHANNELS; k = k + 1)
        begin
            if (onehot[k])
                pick9 = flat[9*k +: 9];
        end
    end
endfunction

// ----------------------------------------
// Address decode
// ----------------------------------------
// Only the addressed slot with status access enabled takes part
assign selected = status_enable && (slot_addr == SLOT_ID);
assign take_write = selected && bus_write;
assign take_read = selected && bus_read;
assign chan_onehot = channel_onehot(channel_addr);
assign chan_write = take_write ? chan_onehot : {CHANNELS{1'b0}};
// Board register decodes under any channel number
assign board_write = take_write && is_board_reg(reg_offset);

// ----------------------------------------
// Framework data pass-through
// ----------------------------------------
// Combinational on purpose: the fanout board latches this data itself
assign fanout_out = framework_in;

// ----------------------------------------
// Channel register groups
// ----------------------------------------
generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : chan
        status_channel u_channel
        (
            .sys_clk(sys_clk),
            .rst(rst),
            .status_in(status_in[9*g +: 9]),
            .wr_status(chan_write[g] && is_status_reg(reg_offset)),
            .wr_mask(chan_write[g] && is_mask_reg(reg_offset)),
            .wr_request(chan_write[g] && is_request_reg(reg_offset)),
            .wr_data(bus_wdata),
            .status(status_all[9*g +: 9]),
            .mask(mask_all[9*g +: 9]),
            .request(request_all[9*g +: 9])
        );
        assign chan_pending[g] = |request_all[9*g +: 9];
    end
endgenerate

assign any_pending = |chan_pending;

// ----------------------------------------
// Read mux
// ----------------------------------------
always @*
begin
    read_status = pick9(status_all, chan_onehot);
    read_mask = pick9(mask_all, chan_onehot);
    read_request = pick9(request_all, chan_onehot);
end

// Unmapped offsets answer with zero
always @*
begin
    next_rdata = RDATA_IDLE;
    if (is_status_reg(reg_offset))
        next_rdata = pad9(read_status);
    else if (is_mask_reg(reg_offset))
        next_rdata = pad9(read_mask);
    else if (is_request_reg(reg_offset))
        next_rdata = pad9(read_request);
    else if (is_board_reg(reg_offset))
        next_rdata = {15'h0000, board_enable};
end

// ----------------------------------------
// Bus answer
// ----------------------------------------
always @*
begin
    next_ack = take_write || take_read;
    next_oe_n = ~take_read;
end

always @(posedge sys_clk)
begin
    if (rst)
    begin
        bus_ack <= 1'b0;
        bus_rdata_oe_n <= 1'b1;
        bus_rdata <= RDATA_IDLE;
    end
    else
    begin
        bus_ack <= next_ack;
        bus_rdata_oe_n <= next_oe_n;
        // Drive zero when idle so a shared read path never sees stale data
        if (take_read)
            bus_rdata <= next_rdata;
        else
            bus_rdata <= RDATA_IDLE;
    end
end

// ----------------------------------------
// Board register
// ----------------------------------------
always @(posedge sys_clk)
begin
    if (rst)
        board_enable <= BOARD_RESET[`BOARD_IRQ_ENABLE_BIT];
    else if (board_write)
        board_enable <= bus_wdata[`BOARD_IRQ_ENABLE_BIT];
end

// ----------------------------------------
// Interrupt
// ----------------------------------------
// The board enable gates the output only; channel requests keep latching
always @*
begin
    next_irq = board_enable && any_pending;
end

always @(posedge sys_clk)
begin
    if (rst)
    begin
        irq_out <= 1'b0;
        irq_led <= 1'b0;
    end
    else
    begin
        irq_out <= next_irq;
        irq_led <= next_irq;
    end
end

// ----------------------------------------
// Status forwarded to the frameworks
// ----------------------------------------
// L1 and L2 busy and error bits of every channel go back to the frameworks
always @*
begin
    next_framework_status = FORWARD_IDLE;
    for (i = 0; i < CHANNELS; i = i + 1)
        next_framework_status[4*i +: 4] = status_in[9*i +: 4];
end

always @(posedge sys_clk)
begin
    if (rst)
        framework_status <= FORWARD_IDLE;
    else
        framework_status <= next_framework_status;
end

endmodule

// *** verilog/status_concentrator_regs.vh ***
`ifndef STATUS_CONCENTRATOR_REGS_VH
`define STATUS_CONCENTRATOR_REGS_VH

// Register offsets within one channel group
`define OFF_CHANNEL_STATUS 3'h0
`define OFF_CHANNEL_INTERRUPT_MASK 3'h2
`define OFF_CHANNEL_INTERRUPT_REQUEST 3'h4
`define OFF_BOARD_INTERRUPT_ENABLE 3'h6

// Address span of the concentrator registers
`define CONC_SPAN_FIRST 11'h400
`define CONC_SPAN_LAST 11'h7fe

// Status bit positions
`define ST_L1_BUSY 0
`define ST_L1_ERROR 1
`define ST_L2_BUSY 2
`define ST_L2_ERROR 3
`define ST_LINK_SYNC_ERROR 4
`define ST_INIT_ACK 5
`define ST_SPARE1 6
`define ST_SPARE2 7
`define ST_CABLE_DISCONNECTED 8
`define ST_USED_BITS 9

// Board register
`define BOARD_IRQ_ENABLE_BIT 0
`define BOARD_USED_BITS 1

// Reset values
`define RESET_CHANNEL_STATUS 16'h0000
`define RESET_CHANNEL_MASK 16'h0000
`define RESET_CHANNEL_REQUEST 16'h0000
`define RESET_BOARD 16'h0000

`endif

// *** verilog/status_channel.v ***
`timescale 1ns/1ps
`include "status_concentrator_regs.vh"

module status_channel
(
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Incoming status signals
    input wire [8:0] status_in,
    // Register writes
    input wire wr_status,
    input wire wr_mask,
    input wire wr_request,
    input wire [15:0] wr_data,
    // Register contents
    output reg [8:0] status,
    output reg [8:0] mask,
    output reg [8:0] request
);

localparam [15:0] STATUS_RESET = `RESET_CHANNEL_STATUS;
localparam [15:0] MASK_RESET = `RESET_CHANNEL_MASK;
localparam [15:0] REQUEST_RESET = `RESET_CHANNEL_REQUEST;

reg [8:0] status_prev;
wire [8:0] rise;

// ----------------------------------------
// Edge detection and request latching
// ----------------------------------------
// Only a fresh inactive-to-active edge raises a request
assign rise = status_in & ~status_prev & mask;

always @(posedge sys_clk)
begin
    if (rst)
    begin
        status <= STATUS_RESET[8:0];
        mask <= MASK_RESET[8:0];
        request <= REQUEST_RESET[8:0];
        status_prev <= 9'h000;
    end
    else
    begin
        status_prev <= status_in;
        // Diagnostic write wins this cycle, otherwise follow live inputs
        if (wr_status)
            status <= wr_data[8:0];
        else
            status <= status_in;
        if (wr_mask)
            mask <= wr_data[8:0];
        // Writing zero clears, one keeps; a new edge wins over the clear
        if (wr_request)
            request <= (request & wr_data[8:0]) | rise;
        else
            request <= request | rise;
    end
end

endmodule

// *** tb/status_concentrator_asserts.sv ***
`timescale 1ns/1ps
module status_concentrator_asserts
#(
    parameter CHANNELS = 8,
    parameter FRAMEWORK_WIDTH = 48,
    parameter [3:0] SLOT_ID = 4'h0
)
(
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Backplane
    input wire status_enable,
    input wire [3:0] slot_addr,
    input wire [2:0] reg_offset,
    input wire bus_write,
    input wire bus_read,
    input wire [15:0] bus_wdata,
    input wire [15:0] bus_rdata,
    input wire bus_rdata_oe_n,
    input wire bus_ack,
    // Status and data
    input wire [9*CHANNELS-1:0] status_in,
    input wire [4*CHANNELS-1:0] framework_status,
    input wire [FRAMEWORK_WIDTH-1:0] framework_in,
    input wire [FRAMEWORK_WIDTH-1:0] fanout_out,
    // Interrupt
    input wire irq_out,
    input wire irq_led
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire sel = status_enable && slot_addr == SLOT_ID && (bus_write || bus_read);
    property p_ack; sel |=> bus_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_noack; !sel |=> !bus_ack; endproperty
    a_noack: assert property (p_noack) else $error("stray ack");
    property p_rd; sel && bus_read |=> !bus_rdata_oe_n; endproperty
    a_rd: assert property (p_rd) else $error("read not driven");
    property p_idle; bus_rdata_oe_n |-> bus_rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("idle data");
    property p_pass; fanout_out == framework_in; endproperty
    a_pass: assert property (p_pass) else $error("pass-through");
    property p_fwd; 1 |=> framework_status[3:0] == $past(status_in[3:0]); endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded status");
    property p_led; irq_led == irq_out; endproperty
    a_led: assert property (p_led) else $error("indicator");
    property p_off; sel && bus_write && reg_offset == 3'h6 && !bus_wdata[0] |=> ##1 !irq_out;
    endproperty
    a_off: assert property (p_off) else $error("irq while disabled");
    cover property (sel && bus_read);
    cover property ($rose(irq_out));
    cover property (sel && bus_write && reg_offset == 3'h6);
endmodule
bind status_concentrator status_concentrator_asserts #(.CHANNELS(CHANNELS),
    .FRAMEWORK_WIDTH(FRAMEWORK_WIDTH), .SLOT_ID(SLOT_ID)) chk_u (.sys_clk, .rst,
    .status_enable, .slot_addr, .reg_offset, .bus_write, .bus_read, .bus_wdata, .bus_rdata,
    .bus_rdata_oe_n, .bus_ack, .status_in, .framework_status, .framework_in, .fanout_out,
    .irq_out, .irq_led);

// *** tb/hub_host_model.sv ***
`timescale 1ns/1ps
module hub_host_model
(
    // Clock
    input wire sys_clk,
    // Backplane
    output reg status_enable = 0,
    output reg [3:0] slot_addr = 0,
    output reg [2:0] channel_addr = 0,
    output reg [2:0] reg_offset = 0,
    output reg bus_write = 0,
    output reg bus_read = 0,
    output reg [15:0] bus_wdata = 0,
    input wire [15:0] bus_rdata,
    input wire bus_ack,
    // Interrupt
    input wire irq_out
);
    wire [2:0] vme_irq_level = irq_out ? 3'h6 : 3'h0;
    task access(input [3:0] sl, input [2:0] ch, input [2:0] off, input wr,
        input [15:0] d, output [15:0] q);
        integer n;
        begin
            @(posedge sys_clk);
            #1;
            {status_enable, slot_addr, channel_addr, reg_offset} = {1'b1, sl, ch, off};
            {bus_write, bus_read, bus_wdata} = {wr, !wr, d};
            n = 0;
            @(posedge sys_clk);
            while (bus_ack !== 1'b1 && n < 4)
            begin
                @(posedge sys_clk);
                n = n + 1;
            end
            q = bus_rdata;
            #1;
            {status_enable, bus_write, bus_read, bus_wdata} = {3'h0, ~d};
        end
    endtask
endmodule

// *** tb/status_concentrator_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin compares = compares + 1; if ((a) !== (e)) begin \
    errors = errors + 1; $display("FAIL %0t %h %h", $time, a, e); end end
module status_concentrator_tb;
    reg sys_clk = 0;
    reg rst = 1;
    reg [71:0] status_in = 0;
    reg [47:0] framework_in = 0;
    wire status_enable, bus_write, bus_read, bus_rdata_oe_n, bus_ack, irq_out, irq_led;
    wire [3:0] slot_addr;
    wire [2:0] channel_addr, reg_offset;
    wire [15:0] bus_wdata, bus_rdata;
    wire [31:0] framework_status;
    wire [47:0] fanout_out;
    integer errors = 0, compares = 0, cycles = 0, i;
    integer seed = 32'h415d3db8;
    reg [15:0] q, w;
    reg [31:0] r;
    function [15:0] as_word(input [8:0] v);
        as_word = {7'h00, v};
    endfunction
    status_concentrator dut_u (.sys_clk, .rst, .status_enable, .slot_addr, .channel_addr,
        .reg_offset, .bus_write, .bus_read, .bus_wdata, .bus_rdata, .bus_rdata_oe_n, .bus_ack,
        .status_in, .framework_status, .framework_in, .fanout_out, .irq_out, .irq_led);
    hub_host_model host_u (.sys_clk, .status_enable, .slot_addr, .channel_addr, .reg_offset,
        .bus_write, .bus_read, .bus_wdata, .bus_rdata, .bus_ack, .irq_out);
    always #25 sys_clk = ~sys_clk;
    task end_of_test;
        begin
            $display("errors=%0d compares=%0d", errors, compares);
            if (errors == 0 && compares > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles > 2000)
        begin
            errors = errors + 1;
            end_of_test;
        end
    end
    task rd(input [2:0] ch, input [2:0] off, input [15:0] e);
        begin
            host_u.access(4'h0, ch, off, 1'b0, 16'h0000, q);
            `CHK(q, e)
        end
    endtask
    task wr(input [2:0] ch, input [2:0] off, input [15:0] d);
        host_u.access(4'h0, ch, off, 1'b1, d, q);
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        #1 rst = 0;
        for (i = 0; i < 8; i = i + 1)
            rd(3'h0, i[2:0], 16'h0000);
        for (i = 0; i < 8; i = i + 1)
        begin
            r = $random(seed);
            w = r[15:0];
            wr(i[2:0], 3'h2, w);
            rd(i[2:0], 3'h2, as_word(w[8:0]));
        end
        wr(3'h0, 3'h2, 16'h0001);
        wr(3'h0, 3'h6, 16'h0001);
        rd(3'h5, 3'h6, 16'h0001);
        host_u.access(4'h3, 3'h0, 3'h2, 1'b1, 16'h0000, q);
        rd(3'h0, 3'h2, 16'h0001);
        status_in[0] = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 `CHK(irq_out, 1'b1)
        `CHK(irq_led, 1'b1)
        `CHK(host_u.vme_irq_level, 3'h6)
        rd(3'h0, 3'h4, 16'h0001);
        wr(3'h0, 3'h4, 16'hfffe);
        rd(3'h0, 3'h4, 16'h0000);
        `CHK(irq_out, 1'b0)
        status_in[0] = 1'b0;
        @(posedge sys_clk) #1 status_in[0] = 1'b1;
        rd(3'h0, 3'h4, 16'h0001);
        wr(3'h0, 3'h6, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1 `CHK(irq_out, 1'b0)
        status_in[71:40] = $random(seed);
        status_in[39:8] = $random(seed);
        framework_in[47:16] = $random(seed);
        r = $random(seed);
        framework_in[15:0] = r[15:0];
        #1 `CHK(fanout_out, framework_in)
        repeat (3) @(posedge sys_clk);
        #1 `CHK(framework_status[11:8], status_in[21:18])
        rd(3'h2, 3'h0, as_word(status_in[26:18]));
        r = $random(seed);
        wr(3'h2, 3'h0, r[15:0]);
        `CHK(dut_u.chan[2].u_channel.status, r[8:0])
        rd(3'h2, 3'h0, as_word(status_in[26:18]));
        @(posedge sys_clk) #1 rst = 1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 0;
        rd(3'h0, 3'h4, 16'h0000);
        end_of_test;
    end
endmodule
